// >>> inc/ups_regs.vh
`ifndef UPS_REGS_VH
`define UPS_REGS_VH

// register offsets
`define UPS_CTRL_OFS      4'h0
`define UPS_STATUS_OFS    4'h4

// control fields
`define UPS_CTRL_DISK_BIT 0
`define UPS_CTRL_SPOF_BIT 1
`define UPS_CTRL_RESET    32'h00000001

// status fields
`define UPS_ST_PWR_BIT    0
`define UPS_ST_ALARM_BIT  1
`define UPS_ST_MAJOR_BIT  2
`define UPS_ST_PWRA_BIT   3
`define UPS_ST_RSCAN_BIT  4
`define UPS_ST_SSCAN_BIT  5
`define UPS_ST_REQ_BIT    6
`define UPS_ST_OOS_BIT    7
`define UPS_ST_PEND_BIT   8
`define UPS_ST_LV_BIT     9
`define UPS_ST_FAN_BIT    10

// bus answers
`define UPS_RESP_OKAY     2'h0
`define UPS_RESP_SLVERR   2'h2

// timing
`define UPS_CLK_KHZ       40000
`define UPS_DEBOUNCE_MS   10
`define UPS_DEBOUNCE_CYC  20'h61A80 // 10 ms at 40 MHz, sized for the counter

`endif

// >>> src/ups_switch.v
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "ups_regs.vh"

// Summary of operation
// - off plus manual override together removes power in any service state.
// - off alone is ignored while the unit is in service.
// - power-off lamp lit whenever power is removed.
// - on control applies power and puts the power-off lamp out.
// - alarm cutoff/test retires the power alarm and lights all lamps.
// - alarm lamp lit while a power alarm is in effect and while alarm cutoff/test is held.
// - scan and alarm points are contacts, closed means one.
// - request scan shows remove/restore requests; status scan shows power and fault.
// - system power-down closes major contact until alarm cutoff pressed.
// - power on with low-voltage fault closes major and power alarm; major ends on cutoff/clear.
// - points read 0000, 1000, 1100, 1110 for the four service conditions.
// - powering up with fault reads 0111 major, 0101 minor.
// - disk package mode alarms when a supply output voltage drops.
// - disk package mode alarms when the cooling fan sensor reports failure.
// - low-voltage alarm turns unit power off.
// - fan alarm turns power off only while out of service.
// - alarms shown on faceplate lamps and forwarded to office alarm contacts.
module ups_switch #(
	parameter        CW     = 20,
	parameter [19:0] DB_CYC = `UPS_DEBOUNCE_CYC
) (
	input  wire        aclk,                    // 40 MHz clock
	input  wire        aresetn,                 // sync reset, low
	input  wire [3:0]  s_axi_awaddr,            // write address
	input  wire        s_axi_awvalid,           // write address valid
	output reg         s_axi_awready,           // write address ready
	input  wire [31:0] s_axi_wdata,             // write data
	input  wire [3:0]  s_axi_wstrb,             // byte enables
	input  wire        s_axi_wvalid,            // write data valid
	output reg         s_axi_wready,            // write data ready
	output reg  [1:0]  s_axi_bresp,             // write response
	output reg         s_axi_bvalid,            // write response valid
	input  wire        s_axi_bready,            // write response ready
	input  wire [3:0]  s_axi_araddr,            // read address
	input  wire        s_axi_arvalid,           // read address valid
	output reg         s_axi_arready,           // read address ready
	output reg  [31:0] s_axi_rdata,             // read data
	output reg  [1:0]  s_axi_rresp,             // read response
	output reg         s_axi_rvalid,            // read data valid
	input  wire        s_axi_rready,            // read data ready
	input  wire        on_switch,               // momentary on
	input  wire        off_switch,              // momentary off
	input  wire        manual_override_switch,  // emergency override
	input  wire        remove_request,          // remove/restore rocker
	input  wire        alarm_cutoff_test_switch, // cutoff and lamp test
	input  wire        request_pending_point,   // system distributor point
	input  wire        out_of_service_point,    // system distributor point
	input  wire        supply_low,              // supply output dropped
	input  wire        fan_fail,                // fan sensor failure
	output reg         power_enable,            // unit power applied
	output reg         off_lamp,                // power-off lamp
	output reg         alarm_lamp,              // alarm lamp
	output reg         oos_lamp,                // out-of-service lamp
	output reg         pending_lamp,            // request pending lamp
	output reg         request_lamp,            // remove request lamp
	output reg         request_scan_point,      // contact, 1 closed
	output reg         status_scan_point,       // contact, 1 closed
	output reg         major_alarm_contact,     // contact, 1 closed
	output reg         power_alarm_contact      // contact, 1 closed
);

	localparam [31:0] CTRL_RST = `UPS_CTRL_RESET;
	wire [8:0] pins;
	reg  [8:0] sync1, sync2;
	wire [4:0] deb;
	reg  [4:0] deb_d;
	wire [4:0] press;
	reg        pend_d, disk_mode, spof_req, req_hold;
	reg        alarm_act, major_sys, major_flt;
	reg        lv_alarm, fan_alarm;
	reg        aw_hold, w_hold;
	reg [3:0]  aw_addr, w_strb;
	reg [31:0] w_data;
	wire       fault, oos, pend, aco, go_off;
	wire [31:0] status_word;

	assign pins = {fan_fail, supply_low, out_of_service_point,
		request_pending_point, alarm_cutoff_test_switch, remove_request,
		manual_override_switch, off_switch, on_switch};

	// two-stage synchronisers for every pin
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1 <= 9'h000;
			sync2 <= 9'h000;
		end
		else
		begin
			sync1 <= pins;
			sync2 <= sync1;
		end
	end

	// per-control debounce: level must hold DB_CYC cycles
	genvar i;
	generate
		for (i = 0; i < 5; i = i + 1)
		begin : g_deb
			reg [CW-1:0] cnt;
			reg          lvl;
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					cnt <= {CW{1'b0}};
					lvl <= 1'b0;
				end
				else if (sync2[i] == lvl)
					cnt <= {CW{1'b0}};
				else if (cnt == DB_CYC - 20'h00001)
				begin
					cnt <= {CW{1'b0}};
					lvl <= sync2[i];
				end
				else
					cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
			end
			assign deb[i] = lvl;
		end
	endgenerate

	// one pulse per debounced press
	always @(posedge aclk)
	begin
		if (!aresetn)
			deb_d <= 5'h00;
		else
			deb_d <= deb;
	end
	assign press = deb & ~deb_d;

	assign oos   = sync2[6];
	assign pend  = sync2[5];
	assign aco   = deb[4];
	assign fault = lv_alarm | fan_alarm;
	assign go_off = (press[1] & deb[2])
		| (press[1] & oos)
		| spof_req
		| lv_alarm
		| (fan_alarm & oos);

	// disk package alarms latch until retired
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lv_alarm  <= 1'b0;
			fan_alarm <= 1'b0;
		end
		else
		begin
			if (disk_mode & sync2[7])
				lv_alarm <= 1'b1;
			else if (press[4])
				lv_alarm <= 1'b0;
			if (disk_mode & sync2[8])
				fan_alarm <= 1'b1;
			else if (press[4])
				fan_alarm <= 1'b0;
		end
	end

	// power state and alarm flags
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			power_enable <= 1'b0;
			alarm_act    <= 1'b0;
			major_sys    <= 1'b0;
			major_flt    <= 1'b0;
			req_hold     <= 1'b0;
			pend_d       <= 1'b0;
		end
		else
		begin
			pend_d <= pend;
			if (go_off)
				power_enable <= 1'b0;
			else if (press[0])
				power_enable <= 1'b1;
			// a newly latched alarm sets, and wins over cutoff
			if (disk_mode & ((sync2[7] & ~lv_alarm) | (sync2[8] & ~fan_alarm)))
				alarm_act <= 1'b1;
			else if (press[4])
				alarm_act <= 1'b0;
			if (spof_req & power_enable)
				major_sys <= 1'b1;
			else if (press[4])
				major_sys <= 1'b0;
			if (power_enable & lv_alarm)
				major_flt <= 1'b1;
			else if (press[4] | ~fault)
				major_flt <= 1'b0;
			// request held until system finishes
			if (press[3])
				req_hold <= 1'b1;
			else if (pend_d & ~pend)
				req_hold <= 1'b0;
		end
	end

	// faceplate lamps and office contacts
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			off_lamp            <= 1'b1;
			alarm_lamp          <= 1'b0;
			oos_lamp            <= 1'b0;
			pending_lamp        <= 1'b0;
			request_lamp        <= 1'b0;
			request_scan_point  <= 1'b1;
			status_scan_point   <= 1'b1;
			major_alarm_contact <= 1'b0;
			power_alarm_contact <= 1'b0;
		end
		else
		begin
			off_lamp     <= ~power_enable | aco;
			alarm_lamp   <= alarm_act | aco;
			oos_lamp     <= oos | aco;
			pending_lamp <= pend | aco;
			request_lamp <= req_hold | aco;
			request_scan_point <= req_hold
				| (~power_enable & ~fault);
			status_scan_point  <= ~power_enable | fault;
			major_alarm_contact <= major_sys | major_flt;
			power_alarm_contact <= fault & alarm_act;
		end
	end

	assign status_word = {21'h000000, fan_alarm, lv_alarm, pend, oos,
		req_hold, status_scan_point, request_scan_point,
		power_alarm_contact, major_alarm_contact, alarm_act,
		power_enable};

	// write channel: address and data taken in any order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `UPS_RESP_OKAY;
			aw_hold       <= 1'b0;
			w_hold        <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			disk_mode     <= CTRL_RST[`UPS_CTRL_DISK_BIT];
			spof_req      <= 1'b0;
		end
		else
		begin
			spof_req      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (s_axi_awvalid & ~aw_hold & ~s_axi_awready)
			begin
				s_axi_awready <= 1'b1;
				aw_hold       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
			end
			if (s_axi_wvalid & ~w_hold & ~s_axi_wready)
			begin
				s_axi_wready <= 1'b1;
				w_hold       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
			end
			if (aw_hold & w_hold & ~s_axi_bvalid)
			begin
				aw_hold      <= 1'b0;
				w_hold       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `UPS_RESP_OKAY;
				if (aw_addr == `UPS_CTRL_OFS)
				begin
					if (w_strb[0])
					begin
						disk_mode <= w_data[`UPS_CTRL_DISK_BIT];
						spof_req <= w_data[`UPS_CTRL_SPOF_BIT];
					end
				end
				else if (aw_addr != `UPS_STATUS_OFS)
					s_axi_bresp <= `UPS_RESP_SLVERR;
			end
			else if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// read channel
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `UPS_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready)
			begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `UPS_RESP_OKAY;
				if (s_axi_araddr == `UPS_CTRL_OFS)
					s_axi_rdata <= {31'h00000000, disk_mode};
				else if (s_axi_araddr == `UPS_STATUS_OFS)
					s_axi_rdata <= status_word;
				else
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `UPS_RESP_SLVERR;
				end
			end
			else if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// >>> verif/unit_power_switch_control_bench.sv
`timescale 1ns/1ps
`include "ups_regs.vh"
module unit_power_switch_control_bench;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, supply_low = 0, fan_fail = 0, deny = 0;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
	logic [4:0] pb = 0;
	logic [31:0] s_axi_wdata = 0, rd;
	logic [1:0] rs;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire on_switch, off_switch, manual_override_switch, remove_request;
	wire alarm_cutoff_test_switch, request_pending_point, out_of_service_point;
	wire power_enable, off_lamp, alarm_lamp, oos_lamp, pending_lamp, request_lamp;
	wire request_scan_point, status_scan_point, major_alarm_contact, power_alarm_contact;
	wire [3:0] pts = {request_scan_point, status_scan_point, major_alarm_contact,
		power_alarm_contact};
	int mismatches = 0, cmp_count = 0;
	// panel buttons as one vector
	assign {on_switch, off_switch, manual_override_switch, remove_request,
		alarm_cutoff_test_switch} = pb;
	always #12.5 aclk = ~aclk;
	ups_switch #(.DB_CYC(20'h4)) i_ups_switch (.*);
	ups_sys_model i_ups_sys_model (.aclk(aclk), .aresetn(aresetn), .deny(deny),
		.request_scan_point(request_scan_point),
		.request_pending_point(request_pending_point),
		.out_of_service_point(out_of_service_point));
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task guard(input int n);
		if (n >= 50)
		begin
			mismatches++;
			report_and_stop;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// hold a button past the debounce, then release
	task press(input logic [4:0] m);
		pb <= m;
		cyc(12);
		pb <= 5'h00;
		cyc(12);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 50 && (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid); n++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		guard(n);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task rdr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 50 && !s_axi_rvalid; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		guard(n);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// main sequence
	initial
	begin
		cyc(12);
		aresetn <= 1'h1;
		cyc(2);
		chk(pts, 4'hC);
		rdr(`UPS_CTRL_OFS, rd, rs);
		chk(rd, `UPS_CTRL_RESET);
		rdr(4'h8, rd, rs);
		chk(rs, `UPS_RESP_SLVERR);
		wr(4'hC, 32'h0, rs);
		chk(rs, `UPS_RESP_SLVERR);
		press(5'h10);
		chk({power_enable, off_lamp, pts}, 6'h20);
		press(5'h08);
		chk(power_enable, 1'h1);
		fan_fail <= 1'h1;
		cyc(12);
		chk({power_enable, pts}, 5'h15);
		fan_fail <= 1'h0;
		press(5'h01);
		chk(power_alarm_contact, 1'h0);
		press(5'h0C);
		chk({power_enable, off_lamp, pts}, 6'h1C);
		cyc(60);
		deny <= 1'h1;
		press(5'h10);
		press(5'h02);
		chk(pts, 4'h8);
		cyc(60);
		press(5'h08);
		chk(power_enable, 1'h0);
		press(5'h10);
		wr(`UPS_CTRL_OFS, 32'h3, rs);
		cyc(6);
		chk({power_enable, pts}, 5'h0E);
		pb <= 5'h01;
		cyc(12);
		chk({off_lamp, alarm_lamp, oos_lamp, pending_lamp, request_lamp}, 5'h1F);
		pb <= 5'h00;
		cyc(12);
		chk(major_alarm_contact, 1'h0);
		press(5'h10);
		supply_low <= 1'h1;
		cyc(12);
		chk({power_enable, alarm_lamp, pts}, 6'h17);
		rdr(`UPS_STATUS_OFS, rd, rs);
		chk(rd[`UPS_ST_LV_BIT], 1'h1);
		supply_low <= 1'h0;
		press(5'h01);
		chk(alarm_lamp, 1'h0);
		press(5'h10);
		fan_fail <= 1'h1;
		cyc(12);
		chk(power_enable, 1'h0);
		rdr(`UPS_STATUS_OFS, rd, rs);
		chk(rd[`UPS_ST_FAN_BIT], 1'h1);
		report_and_stop;
	end
endmodule

// >>> verif/ups_switch_assertions.sv
`timescale 1ns/1ps
module ups_switch_assertions #(
	parameter [19:0] DB_CYC = 20'h4
) (
	input wire aclk,                     // clock
	input wire aresetn,                  // reset, low
	input wire alarm_cutoff_test_switch, // cutoff pin
	input wire supply_low,               // supply pin
	input wire s_axi_awready,            // bus
	input wire s_axi_wready,             // bus
	input wire s_axi_bvalid,             // bus
	input wire s_axi_arready,            // bus
	input wire s_axi_rvalid,             // bus
	input wire power_enable,             // power
	input wire off_lamp,                 // lamp
	input wire alarm_lamp,               // lamp
	input wire oos_lamp,                 // lamp
	input wire pending_lamp,             // lamp
	input wire request_lamp,             // lamp
	input wire status_scan_point,        // contact
	input wire major_alarm_contact,      // contact
	input wire power_alarm_contact       // contact
);
	int hc;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles the cutoff pin has been held
	always @(posedge aclk)
		hc <= (!aresetn || !alarm_cutoff_test_switch) ? 0 : hc + 1;
	AST_OFF_LAMP: assert property ($fell(power_enable) |-> ##[0:2] off_lamp)
		else $error("off lamp not lit");
	AST_ON_LAMP: assert property ($rose(power_enable) && !alarm_cutoff_test_switch
		|-> ##[0:2] !off_lamp) else $error("off lamp still lit");
	AST_TEST_LAMPS: assert property (hc == DB_CYC + 6
		|-> off_lamp && alarm_lamp && oos_lamp && pending_lamp && request_lamp)
		else $error("lamp test incomplete");
	AST_ALARM_LAMP: assert property ($rose(power_alarm_contact) |-> ##[0:2] alarm_lamp)
		else $error("alarm lamp dark");
	AST_MAJOR_STATUS: assert property ($rose(major_alarm_contact) |-> ##[0:2] status_scan_point)
		else $error("status scan open");
	AST_LV_OFF: assert property (supply_low [*8] |-> !power_enable)
		else $error("power kept on low supply");
	AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready too long");
	AST_AR_RVALID: assert property (s_axi_arready |-> s_axi_rvalid)
		else $error("read answer late");
	AST_B_AFTER: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
		else $error("write answer late");
	cover property ($fell(power_enable));
	cover property ($rose(major_alarm_contact));
	cover property ($rose(power_alarm_contact));
endmodule
bind ups_switch ups_switch_assertions #(.DB_CYC(DB_CYC)) i_ups_switch_assertions (.*);

// >>> verif/ups_sys_model.sv
`timescale 1ns/1ps
// system side: acks a closing request contact, then grants or denies
module ups_sys_model (
	input  wire aclk,                  // clock
	input  wire aresetn,               // reset, low
	input  wire deny,                  // deny coming requests
	input  wire request_scan_point,    // request contact
	output reg  request_pending_point, // pending point
	output reg  out_of_service_point   // out-of-service point
);
	reg       last;
	reg [7:0] t;
	// ack, hold 40 cycles, then grant or flash for 20 cycles
	always @(posedge aclk)
	begin
		last <= request_scan_point;
		if (!aresetn)
		begin
			t <= 8'h00;
			request_pending_point <= 1'b0;
			out_of_service_point <= 1'b0;
		end
		else if (t == 8'h00 && request_scan_point && !last)
		begin
			t <= 8'h3C;
			request_pending_point <= 1'b1;
		end
		else if (t != 8'h00)
		begin
			t <= t - 8'h01;
			if (t <= 8'h14)
				request_pending_point <= deny & t[1] & (t != 8'h01);
			if (t == 8'h14 && !deny)
				out_of_service_point <= !out_of_service_point;
		end
	end
endmodule
